// ### rtl/can_node_pkg.sv
// shared constants, frame carrier and codes for the can node service block
package can_node_pkg;

    typedef struct packed {
        logic [63:0] data;
        logic [3:0] dlc;
        logic rtr;
        logic [10:0] id;
    } can_frame_s;

    localparam int unsigned CLK_FREQ_HZ = 100_000_000;
    localparam int unsigned TICK_PERIOD_MS = 1;
    localparam int unsigned CYCLES_PER_MS = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;

    localparam logic [10:0] SDO_RX_BASE = 11'h600;
    localparam logic [10:0] SDO_TX_BASE = 11'h580;
    localparam logic [10:0] ERR_CTRL_BASE = 11'h700;
    localparam logic [10:0] EMCY_BASE = 11'h080;

    localparam logic [7:0] REQ_READ = 8'h40;
    localparam logic [7:0] REQ_WRITE4 = 8'h23;
    localparam logic [7:0] REQ_WRITE2 = 8'h2b;
    localparam logic [7:0] REQ_WRITE1 = 8'h2f;
    localparam logic [7:0] RSP_READ4 = 8'h43;
    localparam logic [7:0] RSP_READ2 = 8'h4b;
    localparam logic [7:0] RSP_READ1 = 8'h4f;
    localparam logic [7:0] RSP_WRITE_OK = 8'h60;
    localparam logic [7:0] RSP_ABORT = 8'h80;

    localparam logic [31:0] ABORT_BAD_CMD = 32'h0504_0001;
    localparam logic [31:0] ABORT_NO_OBJECT = 32'h0602_0000;
    localparam logic [31:0] ABORT_NO_SUB = 32'h0609_0011;
    localparam logic [31:0] ABORT_READ_ONLY = 32'h0601_0002;
    localparam logic [31:0] ABORT_GENERAL = 32'h0800_0000;

    localparam logic [15:0] IDX_GUARD_INTERVAL = 16'h100c;
    localparam logic [15:0] IDX_LIFE_MULTIPLIER = 16'h100d;
    localparam logic [15:0] IDX_HB_CONSUMER = 16'h1016;
    localparam logic [15:0] IDX_HB_PRODUCER = 16'h1017;
    localparam logic [7:0] SUB_MAIN = 8'h00;
    localparam logic [7:0] SUB_HB_CONS_ENTRY = 8'h01;
    localparam logic [7:0] HB_CONS_ENTRIES = 8'h01;

    localparam logic [15:0] GUARD_INTERVAL_RST = 16'h0000;
    localparam logic [7:0] LIFE_MULTIPLIER_RST = 8'h00;
    localparam logic [31:0] HB_CONSUMER_RST = 32'h0000_0000;
    localparam logic [15:0] HB_PRODUCER_RST = 16'h0000;
    localparam int unsigned HB_CONS_NODE_LSB = 16;

    localparam logic [7:0] BOOTUP_BYTE = 8'h00;
    localparam logic [6:0] STATE_STOPPED = 7'h04;
    localparam logic [6:0] STATE_OPERATIONAL = 7'h05;
    localparam logic [6:0] STATE_PREOP = 7'h7f;
    localparam logic [15:0] EMCY_LIFE_GUARD_CODE = 16'h8130;
    localparam logic [7:0] EMCY_ERR_REG = 8'h11;

    localparam logic [3:0] DLC_SDO = 4'h8;
    localparam logic [3:0] DLC_ONE = 4'h1;

endpackage : can_node_pkg

// ### rtl/can_node_sdo_error_control.sv
// expedited sdo server, bootup, node guarding and heartbeat for one node
`timescale 1ns/1ps
module can_node_sdo_error_control
    import can_node_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = CYCLES_PER_MS
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic [6:0] node_id_in,
    input wire logic [6:0] nmt_state_in,
    input wire logic bootup_in,
    input wire logic comm_reset_in,
    input wire logic rx_valid_in,
    input wire can_frame_s rx_frame_in,
    input wire logic tx_ready_in,
    output logic tx_valid_out,
    output can_frame_s tx_frame_out,
    output logic life_guard_event_out,
    output logic heartbeat_event_out,
    output logic comm_fault_out
);
    typedef enum logic [2:0] {
        SRC_EMCY,
        SRC_BOOT,
        SRC_SDO,
        SRC_GUARD,
        SRC_HB,
        SRC_NONE
    } tx_src_e;

    logic rst_meta_q;
    logic rst_n_q;
    logic tick;
    logic [15:0] guard_interval_ms_q;
    logic [7:0] life_multiplier_q;
    logic [31:0] hb_consumer_q;
    logic [15:0] hb_producer_q;
    logic toggle_q;
    logic guard_armed_q;
    logic [4:0] pend_q;
    logic [4:0] pend_set;
    logic [4:0] pend_take;
    can_frame_s sdo_rsp_q;
    tx_src_e sel;
    logic life_expire;
    logic prod_expire;
    logic cons_expire;

    function automatic logic id_match(input logic [10:0] id, input logic [10:0] base,
                                      input logic [6:0] node);
        id_match = (id == base + {4'h0, node});
    endfunction : id_match

    // async assert, two-flop release
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // frame classification
    logic sdo_req;
    logic guard_poll;
    logic hb_seen;
    logic [7:0] req_cmd;
    logic [15:0] req_idx;
    logic [7:0] req_sub;
    logic [31:0] req_data;
    logic guard_cfg;
    logic hb_on;

    assign sdo_req = rx_valid_in && !rx_frame_in.rtr && rx_frame_in.dlc == DLC_SDO
                     && id_match(rx_frame_in.id, SDO_RX_BASE, node_id_in);
    assign guard_poll = rx_valid_in && rx_frame_in.rtr
                        && id_match(rx_frame_in.id, ERR_CTRL_BASE, node_id_in);
    assign hb_seen = rx_valid_in && !rx_frame_in.rtr && rx_frame_in.dlc != 4'h0
                     && id_match(rx_frame_in.id, ERR_CTRL_BASE,
                                 hb_consumer_q[HB_CONS_NODE_LSB+:7]);
    assign req_cmd = rx_frame_in.data[7:0];
    assign req_idx = rx_frame_in.data[23:8];
    assign req_sub = rx_frame_in.data[31:24];
    assign req_data = rx_frame_in.data[63:32];
    assign guard_cfg = guard_interval_ms_q != 16'h0 && life_multiplier_q != 8'h0;
    assign hb_on = hb_producer_q != 16'h0 || hb_consumer_q[15:0] != 16'h0;

    // sdo decode
    logic [7:0] rsp_code;
    logic [31:0] rsp_data;
    logic wr_guard;
    logic wr_life;
    logic wr_cons;
    logic wr_prod;

    always_comb begin
        logic is_write;
        logic known;
        logic sub_ok;
        logic conflict;
        logic [7:0] rd_code;
        logic [31:0] rd_val;
        is_write = req_cmd == REQ_WRITE4 || req_cmd == REQ_WRITE2
                   || req_cmd == REQ_WRITE1;
        known = 1'b1;
        sub_ok = req_sub == SUB_MAIN;
        rd_code = RSP_READ2;
        rd_val = 32'h0;
        conflict = 1'b0;
        wr_guard = 1'b0;
        wr_life = 1'b0;
        wr_cons = 1'b0;
        wr_prod = 1'b0;
        unique case (req_idx)
            IDX_GUARD_INTERVAL: begin
                rd_val = {16'h0, guard_interval_ms_q};
                conflict = hb_on && req_data[15:0] != 16'h0;
            end
            IDX_LIFE_MULTIPLIER: begin
                rd_code = RSP_READ1;
                rd_val = {24'h0, life_multiplier_q};
                conflict = hb_on && req_data[7:0] != 8'h0;
            end
            IDX_HB_CONSUMER: begin
                sub_ok = req_sub == SUB_MAIN || req_sub == SUB_HB_CONS_ENTRY;
                rd_code = req_sub == SUB_MAIN ? RSP_READ1 : RSP_READ4;
                rd_val = req_sub == SUB_MAIN ? {24'h0, HB_CONS_ENTRIES} : hb_consumer_q;
                conflict = guard_cfg && req_data[15:0] != 16'h0;
            end
            IDX_HB_PRODUCER: begin
                rd_val = {16'h0, hb_producer_q};
                conflict = guard_cfg && req_data[15:0] != 16'h0;
            end
            default: known = 1'b0;
        endcase
        rsp_code = RSP_ABORT;
        rsp_data = ABORT_GENERAL;
        if (req_cmd != REQ_READ && !is_write) begin
            rsp_data = ABORT_BAD_CMD;
        end else if (!known) begin
            rsp_data = ABORT_NO_OBJECT;
        end else if (!sub_ok) begin
            rsp_data = ABORT_NO_SUB;
        end else if (req_cmd == REQ_READ) begin
            rsp_code = rd_code;
            rsp_data = rd_val;
        end else if (req_idx == IDX_HB_CONSUMER && req_sub == SUB_MAIN) begin
            rsp_data = ABORT_READ_ONLY;
        end else if (!conflict) begin
            rsp_code = RSP_WRITE_OK;
            rsp_data = 32'h0;
            wr_guard = sdo_req && req_idx == IDX_GUARD_INTERVAL;
            wr_life = sdo_req && req_idx == IDX_LIFE_MULTIPLIER;
            wr_cons = sdo_req && req_idx == IDX_HB_CONSUMER;
            wr_prod = sdo_req && req_idx == IDX_HB_PRODUCER;
        end
    end

    // configuration objects, defaults restored by communication reset
    always_ff @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            guard_interval_ms_q <= GUARD_INTERVAL_RST;
            life_multiplier_q <= LIFE_MULTIPLIER_RST;
            hb_consumer_q <= HB_CONSUMER_RST;
            hb_producer_q <= HB_PRODUCER_RST;
        end else if (comm_reset_in) begin
            guard_interval_ms_q <= GUARD_INTERVAL_RST;
            life_multiplier_q <= LIFE_MULTIPLIER_RST;
            hb_consumer_q <= HB_CONSUMER_RST;
            hb_producer_q <= HB_PRODUCER_RST;
        end else begin
            if (wr_guard) guard_interval_ms_q <= req_data[15:0];
            if (wr_life) life_multiplier_q <= req_data[7:0];
            if (wr_cons) hb_consumer_q <= {8'h0, req_data[23:0]};
            if (wr_prod) hb_producer_q <= req_data[15:0];
        end
    end

    // sdo response frame; a new request overwrites an unsent answer
    always_ff @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sdo_rsp_q <= '0;
        end else if (sdo_req) begin
            sdo_rsp_q.id <= SDO_TX_BASE + {4'h0, node_id_in};
            sdo_rsp_q.rtr <= 1'b0;
            sdo_rsp_q.dlc <= DLC_SDO;
            sdo_rsp_q.data <= {rsp_data, req_sub, req_idx, rsp_code};
        end
    end

    // timers
    ms_tick_gen #(
        .DIVIDE(TICK_CYCLES)
    ) u_tick (
        .clock_in(clock_in),
        .rst_n_in(rst_n_q),
        .tick_out(tick)
    );

    // life guarding starts at the first poll so a slow master is not faulted at boot
    ms_timer #(
        .WIDTH(24)
    ) u_life (
        .clock_in(clock_in),
        .rst_n_in(rst_n_q),
        .enable_in(guard_cfg && guard_armed_q),
        .restart_in(guard_poll),
        .tick_in(tick),
        .period_in({8'h0, guard_interval_ms_q} * {16'h0, life_multiplier_q}),
        .expire_out(life_expire)
    );

    ms_timer #(
        .WIDTH(16)
    ) u_prod (
        .clock_in(clock_in),
        .rst_n_in(rst_n_q),
        .enable_in(hb_producer_q != 16'h0 && !guard_cfg),
        .restart_in(1'b0),
        .tick_in(tick),
        .period_in(hb_producer_q),
        .expire_out(prod_expire)
    );

    ms_timer #(
        .WIDTH(16)
    ) u_cons (
        .clock_in(clock_in),
        .rst_n_in(rst_n_q),
        .enable_in(hb_consumer_q[15:0] != 16'h0 && !guard_cfg),
        .restart_in(hb_seen),
        .tick_in(tick),
        .period_in(hb_consumer_q[15:0]),
        .expire_out(cons_expire)
    );

    // guarding state
    always_ff @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            guard_armed_q <= 1'b0;
            toggle_q <= 1'b0;
        end else if (comm_reset_in) begin
            guard_armed_q <= 1'b0;
            toggle_q <= 1'b0;
        end else begin
            if (guard_poll && guard_cfg) guard_armed_q <= 1'b1;
            if (!guard_cfg) guard_armed_q <= 1'b0;
            if (pend_take[SRC_GUARD]) toggle_q <= ~toggle_q;
        end
    end

    // event outputs; fault holds until communication reset
    always_ff @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            life_guard_event_out <= 1'b0;
            heartbeat_event_out <= 1'b0;
            comm_fault_out <= 1'b0;
        end else begin
            life_guard_event_out <= life_expire;
            heartbeat_event_out <= cons_expire;
            if (life_expire) comm_fault_out <= 1'b1;
            else if (comm_reset_in) comm_fault_out <= 1'b0;
        end
    end

    // pending transmit requests; a new set wins over the take
    always_comb begin
        pend_set = '0;
        pend_set[SRC_EMCY] = life_expire;
        pend_set[SRC_BOOT] = bootup_in;
        pend_set[SRC_SDO] = sdo_req;
        pend_set[SRC_GUARD] = guard_poll && guard_cfg;
        pend_set[SRC_HB] = prod_expire;
    end

    always_comb begin
        sel = SRC_NONE;
        if (!tx_valid_out) begin
            for (int i = 4; i >= 0; i--) begin
                if (pend_q[i]) sel = tx_src_e'(i);
            end
        end
        pend_take = '0;
        if (sel != SRC_NONE) pend_take[sel] = 1'b1;
    end

    always_ff @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~pend_take) | pend_set;
        end
    end

    // transmit register, held until the controller accepts it
    always_ff @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_valid_out <= 1'b0;
            tx_frame_out <= '0;
        end else if (tx_valid_out) begin
            if (tx_ready_in) tx_valid_out <= 1'b0;
        end else if (sel != SRC_NONE) begin
            tx_valid_out <= 1'b1;
            tx_frame_out.rtr <= 1'b0;
            tx_frame_out.dlc <= DLC_ONE;
            tx_frame_out.id <= ERR_CTRL_BASE + {4'h0, node_id_in};
            unique case (sel)
                SRC_EMCY: begin
                    tx_frame_out.id <= EMCY_BASE + {4'h0, node_id_in};
                    tx_frame_out.dlc <= DLC_SDO;
                    tx_frame_out.data <= {40'h0, EMCY_ERR_REG, EMCY_LIFE_GUARD_CODE};
                end
                SRC_BOOT: tx_frame_out.data <= {56'h0, BOOTUP_BYTE};
                SRC_SDO: tx_frame_out <= sdo_rsp_q;
                SRC_GUARD: tx_frame_out.data <= {56'h0, toggle_q, nmt_state_in};
                SRC_HB: tx_frame_out.data <= {56'h0, 1'b0, nmt_state_in};
                default: tx_frame_out.data <= '0;
            endcase
        end
    end

endmodule : can_node_sdo_error_control

// ### rtl/ms_tick_gen.sv
// millisecond tick prescaler
`timescale 1ns/1ps
module ms_tick_gen #(
    parameter int unsigned DIVIDE = 100000
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    output logic tick_out
);
    logic [31:0] count_q;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_q <= 32'h0;
            tick_out <= 1'b0;
        end else if (count_q == DIVIDE[31:0] - 32'h1) begin
            count_q <= 32'h0;
            tick_out <= 1'b1;
        end else begin
            count_q <= count_q + 32'h1;
            tick_out <= 1'b0;
        end
    end
endmodule : ms_tick_gen

// ### rtl/ms_timer.sv
// reloading millisecond countdown, one-cycle expiry pulse
`timescale 1ns/1ps
module ms_timer #(
    parameter int unsigned WIDTH = 24
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic restart_in,
    input wire logic tick_in,
    input wire logic [WIDTH-1:0] period_in,
    output logic expire_out
);
    logic [WIDTH-1:0] remain_q;

    // reload on expiry so a producer keeps running without software help
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            remain_q <= '0;
            expire_out <= 1'b0;
        end else if (!enable_in || restart_in) begin
            remain_q <= period_in;
            expire_out <= 1'b0;
        end else if (remain_q == '0) begin
            // a period written in the enabling cycle lands here, so it is not a false expiry
            remain_q <= period_in;
            expire_out <= 1'b0;
        end else if (tick_in && remain_q <= WIDTH'(1)) begin
            remain_q <= period_in;
            expire_out <= 1'b1;
        end else begin
            remain_q <= tick_in ? remain_q - WIDTH'(1) : remain_q;
            expire_out <= 1'b0;
        end
    end
endmodule : ms_timer

// ### verif/can_master_model.sv
// network master model: sends frames to the node and collects what it transmits
`timescale 1ns/1ps
module can_master_model
    import can_node_pkg::*;
(
    input wire logic clock_in,
    input wire logic slow_in,
    input wire logic tx_valid_in,
    input wire can_frame_s tx_frame_in,
    output logic rx_valid_out,
    output can_frame_s rx_frame_out,
    output logic tx_ready_out
);
    can_frame_s got[$];
    initial begin
        rx_valid_out = 1'b0;
        rx_frame_out = '0;
        tx_ready_out = 1'b0;
    end
    // a slow master takes a frame only every other cycle
    always @(negedge clock_in) tx_ready_out <= slow_in ? !tx_ready_out : 1'b1;
    always @(posedge clock_in) begin
        if (tx_valid_in && tx_ready_out) begin
            got.push_back(tx_frame_in);
        end
    end
    task automatic send(input can_frame_s f);
        @(negedge clock_in);
        rx_frame_out = f;
        rx_valid_out = 1'b1;
        @(negedge clock_in);
        rx_valid_out = 1'b0;
        // released lines must not keep the old frame
        rx_frame_out = ~f;
    endtask : send
    task automatic poll(input logic [6:0] node);
        send('{data: 64'h0, dlc: 4'h0, rtr: 1'b1, id: ERR_CTRL_BASE + 11'(node)});
    endtask : poll
endmodule : can_master_model

// ### verif/can_node_sdo_error_control_bench.sv
// self-checking bench for the node service block
`timescale 1ns/1ps
module can_node_sdo_error_control_bench
    import can_node_pkg::*;
;
    localparam logic [6:0] NODE = 7'h04;
    localparam logic [10:0] EC_ID = ERR_CTRL_BASE + 11'(NODE);
    localparam logic [15:0] RD_IDX [5] = '{16'h100c, 16'h100d, 16'h1017, 16'h1016, 16'h1016};
    localparam logic [7:0] RD_SUB [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    localparam logic [7:0] RD_RSP [5] = '{RSP_READ2, RSP_READ1, RSP_READ2, RSP_READ1, RSP_READ4};
    localparam logic [31:0] RD_VAL [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
    localparam logic [7:0] AB_CMD [4] = '{8'h55, REQ_READ, REQ_READ, REQ_WRITE1};
    localparam logic [15:0] AB_IDX [4] = '{16'h100c, 16'h2000, 16'h100c, 16'h1016};
    localparam logic [7:0] AB_SUB [4] = '{8'h00, 8'h00, 8'h05, 8'h00};
    localparam logic [31:0] AB_CODE [4] = '{ABORT_BAD_CMD, ABORT_NO_OBJECT, ABORT_NO_SUB,
        ABORT_READ_ONLY};
    localparam logic [6:0] ST [3] = '{STATE_PREOP, STATE_OPERATIONAL, STATE_STOPPED};
    logic clock_in;
    logic nrst_in;
    logic bootup_in;
    logic comm_reset_in;
    logic slow;
    logic [6:0] nmt_state;
    logic rx_valid;
    logic tx_ready;
    logic tx_valid;
    logic lg_ev;
    logic hb_ev;
    logic fault;
    can_frame_s rx_frame;
    can_frame_s tx_frame;
    can_frame_s f;
    int n_fail = 0;
    int cmp_count = 0;
    int lg_seen = 0;
    int hb_seen = 0;
    int k;
    time t0;

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        lg_seen <= lg_seen + int'(lg_ev);
        hb_seen <= hb_seen + int'(hb_ev);
    end

    // a short tick keeps millisecond timers to ten cycles per ms
    can_node_sdo_error_control #(.TICK_CYCLES(10)) dut_u (
        .clock_in(clock_in), .nrst_in(nrst_in), .node_id_in(NODE), .nmt_state_in(nmt_state),
        .bootup_in(bootup_in), .comm_reset_in(comm_reset_in), .rx_valid_in(rx_valid),
        .rx_frame_in(rx_frame), .tx_ready_in(tx_ready), .tx_valid_out(tx_valid),
        .tx_frame_out(tx_frame), .life_guard_event_out(lg_ev), .heartbeat_event_out(hb_ev),
        .comm_fault_out(fault)
    );
    can_master_model m_u (
        .clock_in(clock_in), .slow_in(slow), .tx_valid_in(tx_valid), .tx_frame_in(tx_frame),
        .rx_valid_out(rx_valid), .rx_frame_out(rx_frame), .tx_ready_out(tx_ready)
    );

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic take(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] data);
        for (k = 0; k < 300 && m_u.got.size() == 0; k++) @(negedge clock_in);
        check("frame present", 64'(m_u.got.size() > 0), 64'h1);
        if (m_u.got.size() > 0) begin
            f = m_u.got.pop_front();
            check("frame id", 64'(f.id), 64'(id));
            check("frame length", 64'(f.dlc), 64'(dlc));
            check("frame data", f.data, data);
        end
    endtask : take
    // only supervision objects are written, never mapped process-data objects
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] val, input logic [7:0] rsp, input logic [31:0] rval);
        m_u.send('{data: {val, sub, idx, cmd}, dlc: DLC_SDO, rtr: 1'b0,
            id: SDO_RX_BASE + 11'(NODE)});
        take(SDO_TX_BASE + 11'(NODE), DLC_SDO, {rval, sub, idx, rsp});
    endtask : xfer
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        // whole sequence needs about 500 cycles
        #200000;
        n_fail++;
        wrap_up();
    end

    initial begin
        nrst_in = 1'b0;
        bootup_in = 1'b0;
        comm_reset_in = 1'b0;
        slow = 1'b0;
        nmt_state = STATE_PREOP;
        repeat (8) @(negedge clock_in);
        nrst_in = 1'b1;
        repeat (3) @(negedge clock_in);
        bootup_in = 1'b1;
        @(negedge clock_in);
        bootup_in = 1'b0;
        take(EC_ID, DLC_ONE, 64'(BOOTUP_BYTE));
        m_u.poll(NODE);
        repeat (20) @(negedge clock_in);
        check("poll while guarding off", 64'(m_u.got.size()), 64'h0);
        for (int i = 0; i < 5; i++) begin
            xfer(REQ_READ, RD_IDX[i], RD_SUB[i], 32'h0, RD_RSP[i], RD_VAL[i]);
        end
        for (int i = 0; i < 4; i++) begin
            xfer(AB_CMD[i], AB_IDX[i], AB_SUB[i], 32'h1, RSP_ABORT, AB_CODE[i]);
        end
        $display("defaults and aborts done");
        xfer(REQ_WRITE2, IDX_GUARD_INTERVAL, SUB_MAIN, 32'h3, RSP_WRITE_OK, 32'h0);
        xfer(REQ_WRITE1, IDX_LIFE_MULTIPLIER, SUB_MAIN, 32'h2, RSP_WRITE_OK, 32'h0);
        slow = 1'b1;
        xfer(REQ_READ, IDX_GUARD_INTERVAL, SUB_MAIN, 32'h0, RSP_READ2, 32'h3);
        xfer(REQ_READ, IDX_LIFE_MULTIPLIER, SUB_MAIN, 32'h0, RSP_READ1, 32'h2);
        slow = 1'b0;
        xfer(REQ_WRITE2, IDX_HB_PRODUCER, SUB_MAIN, 32'h2, RSP_ABORT, ABORT_GENERAL);
        for (int i = 0; i < 3; i++) begin
            nmt_state = ST[i];
            m_u.poll(NODE);
            take(EC_ID, DLC_ONE, 64'({i[0], ST[i]}));
        end
        // life time is 6 ms, 50 to 60 cycles after the last poll
        for (k = 0; k < 100 && lg_seen == 0; k++) @(negedge clock_in);
        check("life expiry window", 64'(k > 40 && k < 70), 64'h1);
        check("comm fault", 64'(fault), 64'h1);
        take(EMCY_BASE + 11'(NODE), DLC_SDO, {40'h0, EMCY_ERR_REG, EMCY_LIFE_GUARD_CODE});
        comm_reset_in = 1'b1;
        @(negedge clock_in);
        comm_reset_in = 1'b0;
        repeat (20) @(negedge clock_in);
        check("fault after comm reset", 64'(fault), 64'h0);
        m_u.got.delete();
        xfer(REQ_READ, IDX_GUARD_INTERVAL, SUB_MAIN, 32'h0, RSP_READ2, 32'h0);
        xfer(REQ_WRITE2, IDX_GUARD_INTERVAL, SUB_MAIN, 32'h3, RSP_WRITE_OK, 32'h0);
        xfer(REQ_WRITE1, IDX_LIFE_MULTIPLIER, SUB_MAIN, 32'h2, RSP_WRITE_OK, 32'h0);
        m_u.poll(NODE);
        take(EC_ID, DLC_ONE, 64'(STATE_STOPPED));
        xfer(REQ_WRITE1, IDX_LIFE_MULTIPLIER, SUB_MAIN, 32'h0, RSP_WRITE_OK, 32'h0);
        $display("node guarding done");
        check("no heartbeat event", 64'(hb_seen), 64'h0);
        xfer(REQ_WRITE4, IDX_HB_CONSUMER, SUB_HB_CONS_ENTRY, 32'h0005_0004, RSP_WRITE_OK,
            32'h0);
        for (int i = 0; i < 6; i++) begin
            m_u.send('{data: 64'(STATE_OPERATIONAL), dlc: DLC_ONE, rtr: 1'b0,
                id: ERR_CTRL_BASE + 11'h5});
            repeat (20) @(negedge clock_in);
        end
        check("heartbeat in time", 64'(hb_seen), 64'h0);
        repeat (60) @(negedge clock_in);
        check("heartbeat missed", 64'(hb_seen > 0), 64'h1);
        nmt_state = STATE_OPERATIONAL;
        // producer 2 ms stays below the 4 ms consumer time
        xfer(REQ_WRITE2, IDX_HB_PRODUCER, SUB_MAIN, 32'h2, RSP_WRITE_OK, 32'h0);
        take(EC_ID, DLC_ONE, 64'(STATE_OPERATIONAL));
        t0 = $time;
        take(EC_ID, DLC_ONE, 64'(STATE_OPERATIONAL));
        check("heartbeat period", 64'($time - t0), 64'd200);
        $display("heartbeat done");
        wrap_up();
    end
endmodule : can_node_sdo_error_control_bench

// ### verif/can_node_sdo_error_control_checker.sv
// concurrent checks on the node service block ports
`timescale 1ns/1ps
module can_node_sdo_error_control_checker
    import can_node_pkg::*;
(
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic [6:0] node_id_in,
    input wire logic [6:0] nmt_state_in,
    input wire logic bootup_in,
    input wire logic comm_reset_in,
    input wire logic rx_valid_in,
    input wire can_frame_s rx_frame_in,
    input wire logic tx_ready_in,
    input wire logic tx_valid_out,
    input wire can_frame_s tx_frame_out,
    input wire logic life_guard_event_out,
    input wire logic heartbeat_event_out,
    input wire logic comm_fault_out
);
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);
    logic sdo_req;
    logic sdo_rsp;
    logic ec_tx;
    assign sdo_req = rx_valid_in && !rx_frame_in.rtr && rx_frame_in.dlc == DLC_SDO
        && rx_frame_in.id == SDO_RX_BASE + 11'(node_id_in);
    assign sdo_rsp = tx_valid_out && tx_frame_out.id == SDO_TX_BASE + 11'(node_id_in);
    assign ec_tx = tx_valid_out && tx_frame_out.id == ERR_CTRL_BASE + 11'(node_id_in);

    a_tx_hold: assert property (
        tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_frame_out))
        else $error("tx frame changed before acceptance");
    a_tx_release: assert property (
        tx_valid_out && tx_ready_in |=> !tx_valid_out)
        else $error("tx valid kept after acceptance");
    a_sdo_answer: assert property (sdo_req |-> ##[2:40] sdo_rsp)
        else $error("no sdo response in time");
    a_sdo_length: assert property (sdo_rsp |-> tx_frame_out.dlc == DLC_SDO)
        else $error("sdo response not eight bytes");
    a_write_ok_zero: assert property (
        sdo_rsp && tx_frame_out.data[7:0] == RSP_WRITE_OK |-> tx_frame_out.data[63:32] == 32'h0)
        else $error("write response data not zero");
    a_read2_upper_zero: assert property (
        sdo_rsp && tx_frame_out.data[7:0] == RSP_READ2 |-> tx_frame_out.data[63:48] == 16'h0)
        else $error("two-byte read upper bytes not zero");
    a_state_byte: assert property (ec_tx |-> tx_frame_out.dlc == DLC_ONE
        && (tx_frame_out.data[6:0] == nmt_state_in || tx_frame_out.data[7:0] == BOOTUP_BYTE))
        else $error("error control byte wrong");
    a_bootup_frame: assert property (
        bootup_in |-> ##[1:20] (ec_tx && tx_frame_out.data[7:0] == BOOTUP_BYTE))
        else $error("bootup frame missing");
    a_life_fault: assert property (life_guard_event_out |-> ##[0:2] comm_fault_out)
        else $error("fault flag not set on life guard event");
    a_life_emcy: assert property (life_guard_event_out |-> ##[1:30]
        (tx_valid_out && tx_frame_out.id == EMCY_BASE + 11'(node_id_in)))
        else $error("emergency frame missing");
    a_life_pulse: assert property (life_guard_event_out |=> !life_guard_event_out)
        else $error("life guard event longer than one cycle");
    a_hb_pulse: assert property (heartbeat_event_out |=> !heartbeat_event_out)
        else $error("heartbeat event longer than one cycle");

    c_guard_toggle: cover property (ec_tx && tx_frame_out.data[7]);
    c_life_event: cover property (life_guard_event_out);
    c_hb_event: cover property (heartbeat_event_out);
endmodule : can_node_sdo_error_control_checker

bind can_node_sdo_error_control can_node_sdo_error_control_checker chk_u (
    .clock_in(clock_in), .nrst_in(nrst_in), .node_id_in(node_id_in),
    .nmt_state_in(nmt_state_in), .bootup_in(bootup_in), .comm_reset_in(comm_reset_in),
    .rx_valid_in(rx_valid_in), .rx_frame_in(rx_frame_in), .tx_ready_in(tx_ready_in),
    .tx_valid_out(tx_valid_out), .tx_frame_out(tx_frame_out),
    .life_guard_event_out(life_guard_event_out), .heartbeat_event_out(heartbeat_event_out),
    .comm_fault_out(comm_fault_out)
);
